// ### pkg/smid_consts.svh
// Constants for the shift, move and indirect load datapath.
`ifndef SMID_CONSTS_SVH
`define SMID_CONSTS_SVH
`define SMID_DW 8
`define SMID_AW 16
`define SMID_FW 7
`define SMID_KW 6
`define SMID_NPTR 2
`define SMID_WIN0_ADDR 7'h00
`define SMID_WIN1_ADDR 7'h01
`define SMID_ACC_RST 8'h00
`define SMID_PTR_RST 16'h0000
`define SMID_PTR_STEP 16'h0001
`define SMID_MODE_PREINC 2'h0
`define SMID_MODE_PREDEC 2'h1
`define SMID_MODE_POSTINC 2'h2
`define SMID_MODE_POSTDEC 2'h3
`endif

// ### pkg/smid_pkg.sv
// Types shared by the shift, move and indirect load datapath.
`include "smid_consts.svh"
package smid_pkg;
   typedef enum logic [1:0] {
      SMID_LOGICAL_SHIFT_LEFT_OP = 2'h0,
      SMID_LOGICAL_SHIFT_RIGHT_OP = 2'h1,
      SMID_MOVE_FILE_OP = 2'h2,
      SMID_INDIRECT_LOAD_OP = 2'h3
   } smid_opc_t;

   typedef enum logic [1:0] {
      SMID_IDLE = 2'b00,
      SMID_READ = 2'b01,
      SMID_EXEC = 2'b11
   } smid_state_t;

   typedef struct packed {
      smid_opc_t opc;
      logic dest_file;
      logic ptr_sel;
      logic rel;
      logic [1:0] mode;
      logic [`SMID_KW-1:0] offset;
      logic [`SMID_FW-1:0] faddr;
   } smid_op_t;
endpackage

// ### design/smid_ptr_bank.sv
// The two pointer registers with update and load ports.
`timescale 1ns/1ns
`include "smid_consts.svh"
module smid_ptr_bank
   import smid_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic upd_en,
   input wire logic upd_sel,
   input wire logic [`SMID_AW-1:0] upd_data,
   input wire logic ld_en,
   input wire logic ld_sel,
   input wire logic [`SMID_AW-1:0] ld_data,
   output logic [`SMID_NPTR-1:0][`SMID_AW-1:0] ptr_q
);
   wire [`SMID_NPTR-1:0][`SMID_AW-1:0] ptr_d;
   genvar i;
   generate
      for (i = 0; i < `SMID_NPTR; i = i + 1) begin : g_ptr
         wire upd_hit = upd_en && (upd_sel == 1'(i));
         wire ld_hit = ld_en && (ld_sel == 1'(i));
         // The datapath update wins over a load from the core.
         assign ptr_d[i] = upd_hit ? upd_data :
                           ld_hit ? ld_data : ptr_q[i];
      end
   endgenerate

   // One register process for both pointers keeps a single writer.
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ptr_q <= {`SMID_NPTR{`SMID_PTR_RST}};
      end else begin
         ptr_q <= ptr_d;
      end
   end
endmodule

// ### design/smid_datapath.sv
// Datapath for shifts, the file move and the indirect load.
//
// Operation
// (RULE_01) Shift left: bit7 to carry, zero in.
// (RULE_02) Shift right: bit0 to carry, zero in.
// (RULE_03) Shift result to accumulator or file register.
// (RULE_04) File move to accumulator or back to file.
// (RULE_05) File move changes only the zero flag.
// (RULE_06) Indirect address: pointer plus one, minus one, offset.
// (RULE_07) Pointer steps after load; offset mode keeps it.
// (RULE_08) Window register access uses pointer as address.
// (RULE_09) Pointer is 16 bits and wraps around.
// (RULE_10) Zero flag set when 8-bit result zero.
`timescale 1ns/1ns
`include "smid_consts.svh"
module smid_datapath
   import smid_pkg::*;
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic op_valid,
   input wire smid_op_t op,
   input wire logic [`SMID_DW-1:0] mem_rdata,
   input wire logic ptr_ld,
   input wire logic ptr_ld_sel,
   input wire logic [`SMID_AW-1:0] ptr_ld_data,
   output logic busy_q,
   output logic done_q,
   output logic mem_rd_q,
   output logic mem_wr_q,
   output logic [`SMID_AW-1:0] mem_addr_q,
   output logic [`SMID_DW-1:0] mem_wdata_q,
   output logic [`SMID_DW-1:0] acc_q,
   output logic carry_q,
   output logic zero_q,
   output logic [`SMID_NPTR-1:0][`SMID_AW-1:0] ptr_q
);
   smid_state_t state_q;
   smid_state_t state_d;
   smid_op_t op_q;

   wire take = (state_q == SMID_IDLE) && op_valid;
   wire is_ldi = (op.opc == SMID_INDIRECT_LOAD_OP);

   // Effective address and pointer step for the indirect load.
   wire [`SMID_AW-1:0] ptr_cur = ptr_q[op.ptr_sel];
   wire [`SMID_AW-1:0] koff = {{(`SMID_AW-`SMID_KW){op.offset[`SMID_KW-1]}},
                               op.offset};
   wire [`SMID_AW-1:0] ptr_inc = ptr_cur + `SMID_PTR_STEP; // [RULE_09]
   wire [`SMID_AW-1:0] ptr_dec = ptr_cur - `SMID_PTR_STEP; // [RULE_09]
   wire [`SMID_AW-1:0] ptr_rel = ptr_cur + koff;
   wire [`SMID_AW-1:0] ind_ea =
      op.rel ? ptr_rel :
      (op.mode == `SMID_MODE_PREINC) ? ptr_inc :
      (op.mode == `SMID_MODE_PREDEC) ? ptr_dec : ptr_cur; // [RULE_06]
   wire [`SMID_AW-1:0] ptr_new = op.mode[0] ? ptr_dec : ptr_inc; // [RULE_07]
   wire ptr_upd = take && is_ldi && !op.rel; // [RULE_07]

   // A file access to a window register goes to its pointer's address.
   wire win0 = (op.faddr == `SMID_WIN0_ADDR);
   wire win1 = (op.faddr == `SMID_WIN1_ADDR);
   wire [`SMID_AW-1:0] file_ea =
      win1 ? ptr_q[1] :
      win0 ? ptr_q[0] :
      {{(`SMID_AW-`SMID_FW){1'b0}}, op.faddr}; // [RULE_08]
   wire [`SMID_AW-1:0] addr_d = is_ldi ? ind_ea : file_ea;

   // Result of the operation held in op_q on the returned data.
   wire q_lsl = (op_q.opc == SMID_LOGICAL_SHIFT_LEFT_OP);
   wire q_lsr = (op_q.opc == SMID_LOGICAL_SHIFT_RIGHT_OP);
   wire q_ldi = (op_q.opc == SMID_INDIRECT_LOAD_OP);
   wire q_shift = q_lsl || q_lsr;
   wire [`SMID_DW-1:0] res =
      q_lsl ? {mem_rdata[`SMID_DW-2:0], 1'b0} : // [RULE_01]
      q_lsr ? {1'b0, mem_rdata[`SMID_DW-1:1]} : // [RULE_02]
      mem_rdata;
   wire shift_out = q_lsl ? mem_rdata[`SMID_DW-1] : mem_rdata[0];
   wire exec = (state_q == SMID_EXEC);
   wire to_file = exec && op_q.dest_file && !q_ldi; // [RULE_03] [RULE_04]
   wire to_acc = exec && (q_ldi || !op_q.dest_file); // [RULE_03] [RULE_04]
   wire res_zero = (res == `SMID_ACC_RST); // [RULE_10]

   always_comb begin
      case (state_q)
         SMID_IDLE: state_d = take ? SMID_READ : SMID_IDLE;
         SMID_READ: state_d = SMID_EXEC;
         SMID_EXEC: state_d = SMID_IDLE;
         default: state_d = SMID_IDLE;
      endcase
   end

   smid_ptr_bank u_ptr (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .upd_en(ptr_upd),
      .upd_sel(op.ptr_sel),
      .upd_data(ptr_new),
      .ld_en(ptr_ld),
      .ld_sel(ptr_ld_sel),
      .ld_data(ptr_ld_data),
      .ptr_q(ptr_q)
   );

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= SMID_IDLE;
         op_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_addr_q <= `SMID_PTR_RST;
      end else begin
         state_q <= state_d;
         busy_q <= (state_d != SMID_IDLE);
         done_q <= exec;
         mem_rd_q <= take;
         if (take) begin
            op_q <= op;
            mem_addr_q <= addr_d;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_wr_q <= 1'b0;
         mem_wdata_q <= `SMID_ACC_RST;
         acc_q <= `SMID_ACC_RST;
         carry_q <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         mem_wr_q <= to_file;
         if (to_file) begin
            mem_wdata_q <= res;
         end
         if (to_acc) begin
            acc_q <= res;
         end
         if (exec && q_shift) begin
            carry_q <= shift_out; // [RULE_01] [RULE_02]
         end
         if (exec) begin
            zero_q <= res_zero; // [RULE_05] [RULE_10]
         end
      end
   end

   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   wire [`SMID_AW-1:0] ptr_sel_q = ptr_q[op_q.ptr_sel];

   lsl_result_a: assert property ( // [RULE_01]
      exec && q_lsl |=> carry_q == $past(mem_rdata[7]) &&
         (mem_wr_q ? mem_wdata_q : acc_q) ==
         {$past(mem_rdata[6:0]), 1'b0})
      else $error("Left shift result or carry wrong.");

   lsr_result_a: assert property ( // [RULE_02]
      exec && q_lsr |=> carry_q == $past(mem_rdata[0]) &&
         (mem_wr_q ? mem_wdata_q : acc_q) ==
         {1'b0, $past(mem_rdata[7:1])})
      else $error("Right shift result or carry wrong.");

   shift_dest_a: assert property ( // [RULE_03]
      exec && q_shift && op_q.dest_file |=>
         mem_wr_q && $stable(acc_q) && mem_addr_q == $past(mem_addr_q))
      else $error("Shift to file register went astray.");

   move_acc_a: assert property ( // [RULE_04]
      exec && op_q.opc == SMID_MOVE_FILE_OP |=>
         (op_q.dest_file ? mem_wdata_q : acc_q) == $past(mem_rdata) &&
         mem_wr_q == $past(op_q.dest_file))
      else $error("File move destination wrong.");

   move_flags_a: assert property ( // [RULE_05]
      exec && op_q.opc == SMID_MOVE_FILE_OP |=>
         $stable(carry_q) && zero_q == ($past(mem_rdata) == 8'h00))
      else $error("File move touched the wrong flags.");

   preinc_addr_a: assert property ( // [RULE_06]
      take && is_ldi && !op.rel && op.mode == `SMID_MODE_PREINC |=>
         mem_rd_q && mem_addr_q == 16'($past(ptr_cur) + 16'h0001))
      else $error("Preincrement address wrong.");

   ptr_step_a: assert property ( // [RULE_07]
      take && is_ldi && !op.rel && op.mode[0] |=>
         ptr_sel_q == 16'($past(ptr_cur) - 16'h0001))
      else $error("Pointer did not step down.");

   ldi_done_a: assert property ( // [RULE_07]
      take && is_ldi |=> ##2 done_q && acc_q == $past(mem_rdata) &&
         zero_q == ($past(mem_rdata) == 8'h00))
      else $error("Indirect load did not reach the accumulator.");

   window_addr_a: assert property ( // [RULE_08]
      take && !is_ldi && op.faddr == 7'h01 |=>
         mem_addr_q == $past(ptr_q[1]))
      else $error("Window access did not use the pointer.");

   ptr_wrap_a: assert property ( // [RULE_09]
      take && is_ldi && !op.rel && !op.mode[0] && ptr_cur == 16'hffff |=>
         ptr_sel_q == 16'h0000)
      else $error("Pointer did not wrap at the top.");

   lsl_file_c: cover property (exec && q_lsl && op_q.dest_file);
   move_file_op_test_c: cover property (exec && !q_shift && !q_ldi && res_zero);
   ldi_rel_c: cover property (take && is_ldi && op.rel);
   window_c: cover property (take && !is_ldi && win0);
endmodule

// ### bench/tb_smid_datapath.sv
// Self-checking bench for the shift, move and indirect load datapath.
`timescale 1ns/1ns
module tb_smid_datapath
   import smid_pkg::*;
;
   typedef struct packed {
      logic [15:0] a;
      logic [7:0] acc;
      logic c, z, wr;
      logic [7:0] wd;
      logic [15:0] p0, p1;
   } smid_exp_t;
   logic clk_sys = 1'b0, nrst = 1'b0, op_valid = 1'b0;
   logic ptr_ld = 1'b0, ptr_ld_sel = 1'b0, carry_m = 1'b0;
   smid_op_t op = '0;
   logic [7:0] mem_rdata = 8'h00, src = 8'h00, acc_m = 8'h00;
   logic [15:0] ptr_ld_data = 16'h0000, rv;
   logic [15:0] ptr_m [2];
   logic busy_q, done_q, mem_rd_q, mem_wr_q, carry_q, zero_q;
   logic [15:0] mem_addr_q;
   logic [7:0] mem_wdata_q, acc_q;
   logic [1:0][15:0] ptr_q;
   logic [7:0] vals [8] = '{8'h80, 8'h01, 8'h81, 8'h01,
      8'h5a, 8'ha5, 8'h00, 8'hff};
   integer err_total = 0, samples_checked = 0, seed = 32'h55a18367;
   smid_exp_t q [$];
   smid_exp_t e;
   always #20 clk_sys = ~clk_sys;
   smid_datapath uut (.clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid),
      .op(op), .mem_rdata(mem_rdata), .ptr_ld(ptr_ld),
      .ptr_ld_sel(ptr_ld_sel), .ptr_ld_data(ptr_ld_data), .busy_q(busy_q),
      .done_q(done_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q),
      .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q), .acc_q(acc_q),
      .carry_q(carry_q), .zero_q(zero_q), .ptr_q(ptr_q));
   // Read data is only valid in the cycle after the strobe, inverted otherwise.
   always @(posedge clk_sys) mem_rdata <= mem_rd_q ? src : ~src;
   task automatic chk(input string n, input logic [15:0] x, y);
      samples_checked++;
      if (x !== y) begin
         $display("[FAIL] %s expected %h seen %h", n, x, y);
         err_total++;
      end
   endtask
   always @(negedge clk_sys) begin
      if (mem_rd_q === 1'b1 && q.size() > 0) begin
         chk("mem_addr", q[0].a, mem_addr_q);
         chk("busy", 16'h0001, {15'h0, busy_q});
      end
      if (done_q === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         chk("idle", 16'h0000, {15'h0, busy_q});
         chk("acc", {8'h00, e.acc}, {8'h00, acc_q});
         chk("flags", {14'h0, e.c, e.z}, {14'h0, carry_q, zero_q});
         chk("wr", {15'h0, e.wr}, {15'h0, mem_wr_q});
         if (e.wr)
            chk("wdata", {8'h00, e.wd}, {8'h00, mem_wdata_q});
         chk("ptr0", e.p0, ptr_q[0]);
         chk("ptr1", e.p1, ptr_q[1]);
      end
   end
   task automatic ld(input logic s, input logic [15:0] v);
      @(posedge clk_sys);
      ptr_ld <= 1'b1;
      ptr_ld_sel <= s;
      ptr_ld_data <= v;
      @(posedge clk_sys);
      ptr_ld <= 1'b0;
      ptr_m[s] = v;
   endtask
   task automatic run(input logic [1:0] oc, input logic d, ps, rl,
      input logic [1:0] md, input logic [5:0] off, input logic [6:0] fa,
      input logic [7:0] s);
      smid_op_t o;
      smid_exp_t x;
      logic [15:0] p;
      logic [7:0] r;
      int n;
      p = ptr_m[ps];
      x.a = (fa < 7'h02) ? ptr_m[fa[0]] : {9'h000, fa};
      r = s;
      case (oc)
         2'h0: begin r = {s[6:0], 1'b0}; carry_m = s[7]; end
         2'h1: begin r = {1'b0, s[7:1]}; carry_m = s[0]; end
         2'h3: begin
            x.a = rl ? p + {{10{off[5]}}, off} : md == 2'h0 ? p + 16'h0001 :
               md == 2'h1 ? p - 16'h0001 : p;
            if (!rl) ptr_m[ps] = md[0] ? p - 16'h0001 : p + 16'h0001;
         end
         default: ;
      endcase
      x.wr = (oc != 2'h3) && d;
      if (!x.wr) acc_m = r;
      x.acc = acc_m;
      x.c = carry_m;
      x.z = (r == 8'h00);
      x.wd = r;
      x.p0 = ptr_m[0];
      x.p1 = ptr_m[1];
      q.push_back(x);
      o = '{opc: smid_opc_t'(oc), dest_file: d, ptr_sel: ps, rel: rl,
         mode: md, offset: off, faddr: fa};
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op <= o;
      src <= s;
      @(posedge clk_sys);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (done_q !== 1'b1 && n < 10);
      if (n >= 10) begin
         $display("[FAIL] done expected 1 seen %b", done_q);
         err_total++;
      end
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      err_total++;
      close_out();
   end
   initial begin
      ptr_m[0] = 16'h0000;
      ptr_m[1] = 16'h0000;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      @(negedge clk_sys);
      chk("reset", 16'h0000, {8'h00, acc_q} | ptr_q[0] | ptr_q[1]);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
         run({1'b0, i[0]}, i[1], 1'b0, 1'b0, 2'h0, 6'h00, 7'h20, vals[i]);
      $display("test shifts done");
      run(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 7'h7f, 8'h00);
      run(2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 7'h02, 8'h3c);
      run(2'h2, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 7'h41, 8'h00);
      ld(1'b0, 16'h1234);
      ld(1'b1, 16'hbeef);
      run(2'h2, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 7'h00, 8'h77);
      run(2'h0, 1'b1, 1'b0, 1'b0, 2'h0, 6'h00, 7'h01, 8'h40);
      $display("test move done");
      ld(1'b0, 16'hffff);
      run(2'h3, 1'b0, 1'b0, 1'b0, 2'h0, 6'h00, 7'h00, 8'h00);
      ld(1'b1, 16'h0000);
      run(2'h3, 1'b1, 1'b1, 1'b0, 2'h1, 6'h00, 7'h00, 8'h11);
      run(2'h3, 1'b0, 1'b1, 1'b0, 2'h2, 6'h00, 7'h00, 8'h22);
      run(2'h3, 1'b0, 1'b0, 1'b0, 2'h3, 6'h00, 7'h00, 8'h33);
      run(2'h3, 1'b0, 1'b0, 1'b1, 2'h0, 6'h20, 7'h00, 8'h44);
      run(2'h3, 1'b0, 1'b1, 1'b1, 2'h3, 6'h1f, 7'h00, 8'h55);
      $display("test indirect done");
      repeat (60) begin
         rv = 16'($random(seed));
         if (rv[15]) ld(rv[14], 16'($random(seed)));
         run(rv[1:0], rv[2], rv[3], rv[4], rv[6:5], rv[12:7],
            7'h02 + 7'(rv[14:8] % 7'h7e), 8'($random(seed)));
      end
      $display("test random done");
      close_out();
   end
endmodule
